/* File: pkg/acr_pkg.sv */
/*
 Constants of the acquisition control register bank: offsets, reset
 values, field positions and control codes.
 Assumes an 8-bit register space reached by a byte-wide access port.
*/
package acr_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ACR_OFS_SHUTTER = 8'hA4;
	localparam logic [7:0] ACR_OFS_POWER = 8'hA5;
	localparam logic [7:0] ACR_OFS_DELAY = 8'hAE;
	localparam logic [7:0] ACR_OFS_SLAVE = 8'hCA;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] ACR_RST_SHUTTER = 8'h00;
	localparam logic [7:0] ACR_RST_POWER = 8'h07;
	localparam logic [7:0] ACR_RST_DELAY = 8'h01;
	localparam logic [7:0] ACR_RST_SLAVE = 8'h20;
	localparam logic [7:0] ACR_RD_UNMAPPED = 8'h00;
	// ****************************************
	// field positions and codes
	// ****************************************
	localparam int ACR_BIT_RELEASE = 0;
	localparam int ACR_BIT_MULTI = 1;
	localparam int ACR_HIGH_LSB = 3;
	localparam int ACR_STRAP_LSB = 1;
	localparam logic [7:0] ACR_POWER_OFF = 8'h00;
	localparam logic [7:0] ACR_DELAY_NONE = 8'h01;
	localparam logic [7:0] ACR_DELAY_MANUAL = 8'h04;
	localparam logic [4:0] ACR_RST_HIGH = ACR_RST_SLAVE[7:3];
endpackage

/* File: pkg/acr_if.sv */
/*
 Carrier between the register bank and its slave address unit.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface acr_if;
	logic wr_en;
	logic [7:0] wdata;
	logic [7:0] reg_val;
	logic [6:0] active_addr;
	modport bank (output wr_en, output wdata, input reg_val,
		input active_addr);
	modport unit (input wr_en, input wdata, output reg_val,
		output active_addr);
endinterface

/* File: logic/acr_addr_unit.sv */
/*
 Slave address unit: strap capture, programmable high bits and the
 address that the bus slave answers to.
 Assumes the strap pins are stable while reset is held.
*/
`timescale 1ns/1ns
module acr_addr_unit
	import acr_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// straps and startup load
	input wire logic [1:0] i_strap_addr,
	input wire logic i_nvm_valid,
	input wire logic [4:0] i_nvm_addr,
	// general call reload
	input wire logic i_gc_reload,
	// bank side
	acr_if.unit bus
);
	logic [1:0] strap_q;
	logic [4:0] high_q;
	logic [6:0] active_q;
	logic [4:0] high_d;

	// ****************************************
	// programmable high bits
	// ****************************************
	assign high_d = bus.wr_en ? bus.wdata[7:3] :
		(i_nvm_valid ? i_nvm_addr : high_q); // [R9]

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			strap_q <= i_strap_addr; // [R8]
			high_q <= ACR_RST_HIGH; // [R11]
			active_q <= {ACR_RST_HIGH, i_strap_addr};
		end
		else
		begin
			high_q <= high_d;
			if (i_gc_reload)
				active_q <= {high_q, strap_q}; // [R10]
		end
	end

	assign bus.reg_val = {high_q, strap_q, 1'b0};
	assign bus.active_addr = active_q;

	// ****************************************
	// checks
	// ****************************************
	strap_fixed_a: assert property (@(posedge i_clk_sys) // [R8]
		disable iff (i_reset) $stable(strap_q))
		else $error("strap bits changed after reset");
	reload_only_a: assert property (@(posedge i_clk_sys) // [R10]
		disable iff (i_reset)
		!$past(i_gc_reload) |-> $stable(active_q))
		else $error("address changed without reload");
	reload_take_a: assert property (@(posedge i_clk_sys) // [R10]
		disable iff (i_reset)
		i_gc_reload |=> active_q == {$past(high_q), strap_q})
		else $error("reload did not apply programmed address");
	nvm_load_a: assert property (@(posedge i_clk_sys) // [R9]
		disable iff (i_reset)
		i_nvm_valid && !bus.wr_en |=> high_q == $past(i_nvm_addr))
		else $error("startup load not stored");
endmodule

/* File: logic/acr_regs.sv */
/*
 Acquisition control register bank: shutter release and frame mode,
 power control, delay line selection and the slave address register.
 Assumes a two-wire slave in front of it that issues one-cycle read and
 write strobes with an offset, and flags the general-call reload.
*/
//
// Functional notes
// [R1] In single-shot mode a set release bit starts one acquisition and is then cleared by hardware.
// [R2] In multiple-frame mode the release bit stays set after acquisition.
// [R3] With multiple frames set, frames run continuously while release is set.
// [R4] Multiple frames resets to zero, giving single-shot operation.
// [R5] Power control value 0x00 turns the sensor off; reset value 0x07 keeps it on.
// [R6] Delay control 0x01 applies no delay, 0x04 applies the manual delay setting.
// [R7] Changing delay control from 0x01 to 0x04 itself produces a delay step.
// [R8] The two low address bits come from straps captured only during reset.
// [R9] The five high address bits load from a host write or a startup load.
// [R10] A new address takes effect only on the general-call reload command.
// [R11] Slave address resets to 0x20 and shutter reserved bits reset to zero.
// [R12] The host stops continuous acquisition by clearing the release bit.
`timescale 1ns/1ns
module acr_regs
	import acr_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// register access
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	// address control
	input wire logic [1:0] i_strap_addr,
	input wire logic i_nvm_valid,
	input wire logic [4:0] i_nvm_addr,
	input wire logic i_gc_reload,
	output logic [6:0] o_slave_addr,
	// acquisition control
	output logic o_acq_start,
	output logic o_acq_run,
	output logic o_power_on,
	// delay line
	output logic o_delay_manual,
	output logic o_delay_step
);
	acr_if addr_bus ();

	logic [7:0] shutter_q;
	logic [7:0] power_q;
	logic [7:0] delay_q;
	logic [7:0] rdata_q;
	logic rd_valid_q;
	logic acq_start_q;
	logic acq_run_q;
	logic power_on_q;
	logic delay_manual_q;
	logic delay_step_q;
	logic [7:0] shutter_d;
	logic [7:0] rdata_d;

	// ****************************************
	// decode
	// ****************************************
	wire sel_shutter = i_addr == ACR_OFS_SHUTTER;
	wire sel_power = i_addr == ACR_OFS_POWER;
	wire sel_delay = i_addr == ACR_OFS_DELAY;
	wire sel_slave = i_addr == ACR_OFS_SLAVE;
	wire wr_shutter = i_wr_en && sel_shutter;
	wire wr_power = i_wr_en && sel_power;
	wire wr_delay = i_wr_en && sel_delay;
	wire release_set = shutter_q[ACR_BIT_RELEASE];
	wire multi_mode = shutter_q[ACR_BIT_MULTI];
	wire single_fire = release_set && !multi_mode; // [R1] [R4]
	wire delay_kick = wr_delay && delay_q == ACR_DELAY_NONE &&
		i_wdata == ACR_DELAY_MANUAL; // [R7]

	assign addr_bus.wr_en = i_wr_en && sel_slave;
	assign addr_bus.wdata = i_wdata;

	// ****************************************
	// shutter next value
	// ****************************************
	// host write wins over the auto clear
	always_comb
	begin
		shutter_d = shutter_q;
		if (wr_shutter)
			shutter_d = {6'h00, i_wdata[1:0]}; // [R11]
		else if (single_fire)
			shutter_d[ACR_BIT_RELEASE] = 1'b0; // [R1] [R2]
	end

	assign rdata_d = sel_shutter ? shutter_q :
		sel_power ? power_q :
		sel_delay ? delay_q :
		sel_slave ? addr_bus.reg_val : ACR_RD_UNMAPPED;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			shutter_q <= ACR_RST_SHUTTER; // [R4] [R11]
			power_q <= ACR_RST_POWER;
			delay_q <= ACR_RST_DELAY;
		end
		else
		begin
			shutter_q <= shutter_d;
			if (wr_power)
				power_q <= i_wdata;
			if (wr_delay)
				delay_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			rdata_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= i_rd_en;
			if (i_rd_en)
				rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			acq_start_q <= 1'b0;
			acq_run_q <= 1'b0;
			power_on_q <= 1'b1;
			delay_manual_q <= 1'b0;
			delay_step_q <= 1'b0;
		end
		else
		begin
			acq_start_q <= single_fire; // [R1]
			acq_run_q <= release_set && multi_mode; // [R3] [R12]
			power_on_q <= power_q != ACR_POWER_OFF; // [R5]
			delay_manual_q <= delay_q == ACR_DELAY_MANUAL; // [R6]
			delay_step_q <= delay_kick; // [R7]
		end
	end

	assign o_rdata = rdata_q;
	assign o_rd_valid = rd_valid_q;
	assign o_acq_start = acq_start_q;
	assign o_acq_run = acq_run_q;
	assign o_power_on = power_on_q;
	assign o_delay_manual = delay_manual_q;
	assign o_delay_step = delay_step_q;
	assign o_slave_addr = addr_bus.active_addr;

	acr_addr_unit u_addr (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_strap_addr(i_strap_addr),
		.i_nvm_valid(i_nvm_valid),
		.i_nvm_addr(i_nvm_addr),
		.i_gc_reload(i_gc_reload),
		.bus(addr_bus.unit)
	);

	// ****************************************
	// checks
	// ****************************************
	sequence single_armed_s;
		release_set && !multi_mode && !wr_shutter;
	endsequence
	sequence fired_cleared_s;
		acq_start_q && !release_set;
	endsequence

	shot_clear_a: assert property (@(posedge i_clk_sys) // [R1]
		disable iff (i_reset) single_armed_s |=> fired_cleared_s)
		else $error("single shot did not start and clear");
	multi_hold_a: assert property (@(posedge i_clk_sys) // [R2]
		disable iff (i_reset)
		release_set && multi_mode && !wr_shutter |=> release_set)
		else $error("release cleared in multiple frame mode");
	run_level_a: assert property (@(posedge i_clk_sys) // [R3]
		disable iff (i_reset)
		release_set && multi_mode ##1 release_set && multi_mode
		|-> acq_run_q && !acq_start_q)
		else $error("continuous run not held");
	reset_mode_a: assert property (@(posedge i_clk_sys) // [R4]
		!i_reset && $past(i_reset)
		|-> !multi_mode && shutter_q == ACR_RST_SHUTTER)
		else $error("frame mode not single shot after reset");
	power_map_a: assert property (@(posedge i_clk_sys) // [R5]
		disable iff (i_reset)
		$past(power_q) == ACR_POWER_OFF && !$past(i_reset)
		|-> !power_on_q)
		else $error("power not off for zero code");
	delay_sel_a: assert property (@(posedge i_clk_sys) // [R6]
		disable iff (i_reset)
		$past(delay_q) == ACR_DELAY_NONE |-> !delay_manual_q)
		else $error("delay applied for no delay code");
	delay_step_a: assert property (@(posedge i_clk_sys) // [R7]
		disable iff (i_reset)
		wr_delay && delay_q == ACR_DELAY_NONE
		&& i_wdata == ACR_DELAY_MANUAL |=> delay_step_q ##1 delay_manual_q)
		else $error("delay change gave no step");
	reserved_zero_a: assert property (@(posedge i_clk_sys) // [R11]
		disable iff (i_reset) shutter_q[7:2] == 6'h00)
		else $error("shutter reserved bits not zero");
	slave_reset_a: assert property (@(posedge i_clk_sys) // [R11]
		!i_reset && $past(i_reset)
		|-> addr_bus.reg_val[7:3] == ACR_RST_HIGH)
		else $error("slave address high bits wrong after reset");
endmodule

/* File: tb/acr_host_model.sv */
/*
 Host controller model on the register port: byte writes, byte reads
 and the general-call reload strobe.
 Assumes the bank takes strobes on the rising edge of i_clk_sys.
*/
`timescale 1ns/1ns
module acr_host_model
	import acr_pkg::*;
(
	// clock
	input wire logic i_clk_sys,
	// bank answers
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_valid,
	// requests
	output logic o_wr_en = 1'b0,
	output logic o_rd_en = 1'b0,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_wdata = 8'h00,
	output logic o_gc_reload = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk_sys);
		o_wr_en <= 1'b0;
		// released data does not keep its old value
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk_sys);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_clk_sys);
		o_rd_en <= 1'b0;
		#1;
		d = i_rd_valid ? i_rdata : 8'hXX;
	endtask
	// new address only takes effect on this command
	task automatic reload();
		@(posedge i_clk_sys);
		o_gc_reload <= 1'b1;
		@(posedge i_clk_sys);
		o_gc_reload <= 1'b0;
	endtask
endmodule

/* File: tb/acquisition_control_regs_tb.sv */
/*
 Self-checking bench of the acquisition control register bank.
 Assumes acr_host_model as the register host; strap pins start at 2'b11 and drop to 2'b00 before the second reset.
*/
`timescale 1ns/1ns
module acquisition_control_regs_tb
	import acr_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, nvm_v = 1'b0;
	logic [1:0] strap = 2'b11;
	logic [4:0] nvm_a = 5'h00;
	logic wr, rd_en, gc, rd_v, start, run, pwr, man, step;
	logic [7:0] addr, wd, rdata, v;
	logic [6:0] sa;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	// offset, written value, value read back
	logic [23:0] rows [8] = '{24'hA5_00_00, 24'hA5_07_07, 24'hAE_04_04,
		24'hAE_01_01, 24'hA4_FE_02, 24'hA4_00_00, 24'hCA_FF_FE,
		24'h55_AA_00};
	acr_regs dut_u (.i_clk_sys(clk), .i_reset(rst), .i_wr_en(wr),
		.i_rd_en(rd_en), .i_addr(addr), .i_wdata(wd), .o_rdata(rdata),
		.o_rd_valid(rd_v), .i_strap_addr(strap), .i_nvm_valid(nvm_v),
		.i_nvm_addr(nvm_a), .i_gc_reload(gc), .o_slave_addr(sa),
		.o_acq_start(start), .o_acq_run(run), .o_power_on(pwr),
		.o_delay_manual(man), .o_delay_step(step));
	acr_host_model host_u (.i_clk_sys(clk), .i_rdata(rdata),
		.i_rd_valid(rd_v), .o_wr_en(wr), .o_rd_en(rd_en), .o_addr(addr),
		.o_wdata(wd), .o_gc_reload(gc));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		// ****************************************
		// reset values
		// ****************************************
		chk("slave_addr", {1'b0, sa}, 8'h13);
		chk("power_on", {7'h0, pwr}, 8'h01);
		host_u.rd(8'hA4, v);
		chk("shutter", v, 8'h00);
		host_u.rd(8'hA5, v);
		chk("power", v, 8'h07);
		host_u.rd(8'hAE, v);
		chk("delay", v, 8'h01);
		host_u.rd(8'hCA, v);
		chk("slave", v, 8'h26);
		// ****************************************
		// table rows
		// ****************************************
		foreach (rows[i])
		begin
			host_u.wr(rows[i][23:16], rows[i][15:8]);
			host_u.rd(rows[i][23:16], v);
			chk("row", v, rows[i][7:0]);
		end
		// ****************************************
		// awkward cases
		// ****************************************
		host_u.wr(8'hA5, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("power_off", {7'h0, pwr}, 8'h00);
		host_u.wr(8'hAE, 8'h04);
		#1 chk("delay_step", {7'h0, step}, 8'h01);
		@(posedge clk);
		#1 chk("delay_manual", {7'h0, man}, 8'h01);
		host_u.wr(8'hA4, 8'h01);
		@(posedge clk);
		#1 chk("acq_start", {7'h0, start}, 8'h01);
		host_u.rd(8'hA4, v);
		chk("auto_clear", v, 8'h00);
		host_u.wr(8'hA4, 8'h03);
		repeat (2) @(posedge clk);
		#1 chk("acq_run", {7'h0, run}, 8'h01);
		host_u.rd(8'hA4, v);
		chk("release_kept", v, 8'h03);
		// host stops continuous acquisition
		host_u.wr(8'hA4, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk("acq_stop", {7'h0, run}, 8'h00);
		// address: straps ignored after reset, reload needed
		@(posedge clk);
		strap <= 2'b00;
		host_u.wr(8'hCA, 8'h50);
		repeat (2) @(posedge clk);
		#1 chk("addr_hold", {1'b0, sa}, 8'h13);
		host_u.reload();
		#1 chk("addr_host", {1'b0, sa}, 8'h2B);
		@(posedge clk);
		nvm_v <= 1'b1;
		nvm_a <= 5'h1F;
		@(posedge clk);
		nvm_v <= 1'b0;
		#1 chk("addr_nvm_wait", {1'b0, sa}, 8'h2B);
		host_u.reload();
		#1 chk("addr_nvm", {1'b0, sa}, 8'h7F);
		host_u.rd(8'hCA, v);
		chk("slave_rd", v, 8'hFE);
		// second reset takes the new strap level
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 chk("strap_again", {1'b0, sa}, 8'h10);
		host_u.rd(8'hCA, v);
		chk("slave_again", v, 8'h20);
		host_u.rd(8'hA4, v);
		chk("shutter_again", v, 8'h00);
		end_of_test();
	end
endmodule
